// [hw/asid_dec_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface asid_dec_if;
  logic [7:0] instr;
  logic [3:0] mode;
  logic       a0;
  logic       a1;
  logic       addr_zero;
  logic       mid_zero;
  logic       hi_zero;
  logic [2:0] pos_ch;
  logic [2:0] neg_ch;
  logic       neg_com;

  modport dec (input instr, output mode, a0, a1, addr_zero, mid_zero, hi_zero,
               pos_ch, neg_ch, neg_com);
  modport usr (output instr, input mode, a0, a1, addr_zero, mid_zero, hi_zero,
               pos_ch, neg_ch, neg_com);
endinterface

`default_nettype wire

// [hw/asid_instr_decode.sv]
`timescale 1ns/1ns
`default_nettype none

module asid_instr_decode (
  // decode bus
  asid_dec_if.dec d
);

  localparam int A = asid_pkg::ADDR_BITS;

  logic [1:0] pair;
  logic       hi_any;

  always_comb begin
    pair   = 2'h0;
    hi_any = 1'b0;
    // address bits beyond the first two pick the pair, first one weightiest
    for (int i = 2; i < A; i++) begin
      pair   = {pair[0], d.instr[i]};
      hi_any = hi_any | d.instr[i];
    end
    d.mode      = {d.instr[A], d.instr[A+1], d.instr[A+2], d.instr[A+3]};
    d.a0        = d.instr[0];
    d.a1        = d.instr[1];
    d.hi_zero   = ~hi_any;
    d.mid_zero  = ~hi_any & ~d.instr[1];
    d.addr_zero = ~hi_any & ~d.instr[1] & ~d.instr[0];
    // low first bit is differential, bit 1 swaps polarity
    d.neg_com   = d.instr[0];
    d.pos_ch    = {pair, d.instr[1]};
    d.neg_ch    = d.instr[0] ? 3'h0 : {pair, ~d.instr[1]};
  end

endmodule // asid_instr_decode

`default_nettype wire

// [hw/asid_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module asid_pin_sync (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // raw pins
  input  wire logic [asid_pkg::PIN_W-1:0] pins_in,
  // synchronised levels and rising edges
  output logic      [asid_pkg::PIN_W-1:0] lvl,
  output logic      [asid_pkg::PIN_W-1:0] rise
);

  logic [asid_pkg::PIN_W-1:0] m1_r, m2_r, d3_r;
  logic [asid_pkg::PIN_W-1:0] m1_nxt, m2_nxt, d3_nxt;

  // m1_r feeds only m2_r
  always_comb begin
    m1_nxt = rst_b ? pins_in : asid_pkg::PIN_RST;
    m2_nxt = rst_b ? m1_r : asid_pkg::PIN_RST;
    d3_nxt = rst_b ? m2_r : asid_pkg::PIN_RST;
  end

  always_ff @(posedge clk) begin
    m1_r <= m1_nxt;
    m2_r <= m2_nxt;
    d3_r <= d3_nxt;
  end

  assign lvl  = m2_r;
  assign rise = m2_r & ~d3_r;

endmodule // asid_pin_sync

`default_nettype wire

// [hw/asid_pkg.sv]
package asid_pkg;

  // ----------------------------------------
  // variant and instruction layout
  // ----------------------------------------
  localparam int CHANNELS  = 8;
  localparam int ADDR_BITS = (CHANNELS == 2) ? 2 : (CHANNELS == 4) ? 3 : 4;
  localparam logic [4:0] INSTR_LEN = 5'(ADDR_BITS + 4);

  // ----------------------------------------
  // mode field codes, first bit is msb
  // ----------------------------------------
  localparam logic [3:0] MODE_C12_MSB  = 4'h0;
  localparam logic [3:0] MODE_C16_MSB  = 4'h1;
  localparam logic [3:0] MODE_C8_MSB   = 4'h2;
  localparam logic [3:0] MODE_FULLSC   = 4'h3;
  localparam logic [3:0] MODE_C12_LSB  = 4'h4;
  localparam logic [3:0] MODE_C16_LSB  = 4'h5;
  localparam logic [3:0] MODE_C8_LSB   = 4'h6;
  localparam logic [3:0] MODE_OFFSET   = 4'h7;
  localparam logic [3:0] MODE_AUTOCAL  = 4'h8;
  localparam logic [3:0] MODE_AUTOZERO = 4'h9;
  localparam logic [3:0] MODE_PWR_UP   = 4'hA;
  localparam logic [3:0] MODE_PWR_DN   = 4'hB;
  localparam logic [3:0] MODE_STATUS   = 4'hC;
  localparam logic [3:0] MODE_SIGN     = 4'hD;
  localparam logic [3:0] MODE_ACQ      = 4'hE;
  localparam logic [3:0] MODE_TESTSEL  = 4'hF;

  // ----------------------------------------
  // acquisition counts, conversion sources
  // ----------------------------------------
  localparam logic [5:0] ACQ_6     = 6'h06;
  localparam logic [5:0] ACQ_10    = 6'h0A;
  localparam logic [5:0] ACQ_18    = 6'h12;
  localparam logic [5:0] ACQ_34    = 6'h22;
  localparam logic [5:0] ACQ_RESET = ACQ_10;
  localparam logic [1:0] SRC_INPUT  = 2'h0;
  localparam logic [1:0] SRC_FULLSC = 2'h1;
  localparam logic [1:0] SRC_OFFSET = 2'h2;

  // ----------------------------------------
  // status word bits
  // ----------------------------------------
  localparam int ST_PWRUP = 0;
  localparam int ST_PWRDN = 1;
  localparam int ST_CAL = 2;
  localparam int ST_FMT = 3;
  localparam int ST_SIGN = 6;
  localparam int ST_JUST = 7;
  localparam int ST_TEST = 8;

  // ----------------------------------------
  // pin synchroniser slots
  // ----------------------------------------
  localparam int PIN_W = 5;
  localparam int P_SCLK = 0;
  localparam int P_CS = 1;
  localparam int P_SDI = 2;
  localparam int P_RO = 3;
  localparam int P_PDN = 4;
  localparam logic [4:0] PIN_RST = 5'h02;

  typedef enum logic [2:0] {
    FMT8  = 3'h1,
    FMT12 = 3'h2,
    FMT16 = 3'h4
  } asid_fmt_e;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_LOAD  = 4'h2,
    S_SHIFT = 4'h4,
    S_EXEC  = 4'h8
  } asid_state_e;

  function automatic logic [4:0] asid_wlen(asid_fmt_e f, logic s);
    logic [4:0] b;
    b = (f == FMT8) ? 5'h08 : (f == FMT16) ? 5'h10 : 5'h0C;
    return b + {4'h0, s};
  endfunction

  // right aligned, msb-first order; unused upper bits are zero
  function automatic logic [16:0] asid_word(logic [12:0] r, asid_fmt_e f, logic s);
    logic [16:0] w;
    if (f == FMT8) begin
      w = s ? {8'h00, r[12], r[11:4]} : {9'h000, r[11:4]};
    end else begin
      w = s ? {4'h0, r} : {5'h00, r[11:0]};
    end
    return w;
  endfunction

endpackage

// [hw/asid_top.sv]
`timescale 1ns/1ns
`default_nettype none

module asid_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // host serial pins
  input  wire logic        sclk_pin,
  input  wire logic        select_pin_b,
  input  wire logic        serial_instruction_in,
  input  wire logic        read_only_sel,
  input  wire logic        powerdown_pin,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  // converter core status
  input  wire logic [12:0] conv_result,
  input  wire logic        powerup_busy_flag,
  input  wire logic        powerdown_busy_flag,
  input  wire logic        cal_busy_flag,
  // converter core control
  output logic             conv_start,
  output logic             conv_8bit,
  output logic [1:0]       conv_source,
  output logic             autocal_start,
  output logic             autozero_start,
  output logic             power_down,
  output logic [5:0]       acq_cycles,
  output logic             test_mode,
  output logic [7:1]       ch_test_oe,
  // multiplexer
  output logic [2:0]       mux_output_pos_sel,
  output logic [2:0]       mux_output_neg_sel,
  output logic             mux_output_neg_com
);

  // ----------------------------------------
  // pin synchronisers and decoder
  // ----------------------------------------
  logic [asid_pkg::PIN_W-1:0] lvl, rise;
  logic                       s_cs_b, s_sdi, s_ro, s_pdn, s_rise;

  asid_pin_sync u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .pins_in ({powerdown_pin, read_only_sel, serial_instruction_in,
               select_pin_b, sclk_pin}),
    .lvl     (lvl),
    .rise    (rise)
  );

  assign s_cs_b = lvl[asid_pkg::P_CS];
  assign s_sdi  = lvl[asid_pkg::P_SDI];
  assign s_ro   = lvl[asid_pkg::P_RO];
  assign s_pdn  = lvl[asid_pkg::P_PDN];
  assign s_rise = rise[asid_pkg::P_SCLK];

  asid_dec_if dif ();
  asid_instr_decode u_dec (.d(dif.dec));

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  asid_pkg::asid_state_e state_r, state_nxt;
  logic [4:0]  cnt_r, cnt_nxt, len_r, len_nxt;
  logic [7:0]  instr_r, instr_nxt;
  logic [16:0] word_r, word_nxt;
  logic        msbf_r, msbf_nxt, sdo_r, sdo_nxt, oe_r, oe_nxt;

  // configuration state, declared here as the loader reads it
  asid_pkg::asid_fmt_e fmt_r, fmt_nxt;
  logic        sign_r, sign_nxt, msb_r, msb_nxt, stat_r, stat_nxt;
  logic [8:0]  status_word;

  function automatic logic tx_bit(logic [16:0] w, logic [4:0] n, logic [4:0] c,
                                  logic m);
    logic [4:0] i;
    i = m ? (n - 5'h01 - c) : c;
    return (i < 5'h11) ? w[i] : 1'b0;
  endfunction

  always_comb begin
    status_word = '0;
    status_word[asid_pkg::ST_PWRUP] = powerup_busy_flag;
    status_word[asid_pkg::ST_PWRDN] = powerdown_busy_flag;
    status_word[asid_pkg::ST_CAL]  = cal_busy_flag;
    status_word[asid_pkg::ST_FMT +: 3] = fmt_r;
    status_word[asid_pkg::ST_SIGN] = sign_r;
    status_word[asid_pkg::ST_JUST] = msb_r;
    status_word[asid_pkg::ST_TEST] = test_mode;
  end

  assign dif.instr = instr_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    len_nxt   = len_r;
    instr_nxt = instr_r;
    word_nxt  = word_r;
    msbf_nxt  = msbf_r;
    sdo_nxt   = sdo_r;
    oe_nxt    = 1'b0;
    case (state_r)
      asid_pkg::S_IDLE: begin
        // select high keeps the port idle
        if (!s_cs_b) begin
          state_nxt = asid_pkg::S_LOAD;
        end
      end
      asid_pkg::S_LOAD: begin
        // word length follows the format set by the previous instruction
        len_nxt   = asid_pkg::asid_wlen(fmt_r, sign_r);
        msbf_nxt  = stat_r ? 1'b0 : msb_r;
        word_nxt  = stat_r ? {8'h00, status_word}
                           : asid_pkg::asid_word(conv_result, fmt_r, sign_r);
        cnt_nxt   = 5'h00;
        instr_nxt = 8'h00;
        sdo_nxt   = tx_bit(word_nxt, len_nxt, 5'h00, msbf_nxt);
        oe_nxt    = !s_cs_b;
        state_nxt = s_cs_b ? asid_pkg::S_IDLE : asid_pkg::S_SHIFT;
      end
      asid_pkg::S_SHIFT: begin
        oe_nxt = !s_cs_b;
        if (s_cs_b) begin
          // strobed select may end a frame after the instruction alone
          state_nxt = (cnt_r >= asid_pkg::INSTR_LEN) ? asid_pkg::S_EXEC
                                                     : asid_pkg::S_IDLE;
        end else if (s_rise) begin
          if (cnt_r < 5'h08) begin
            instr_nxt[cnt_r[2:0]] = s_sdi;
          end
          cnt_nxt = cnt_r + 5'h01;
          sdo_nxt = tx_bit(word_r, len_r, cnt_nxt, msbf_r);
          if (cnt_nxt == len_r) begin
            state_nxt = asid_pkg::S_EXEC;
          end
        end
      end
      asid_pkg::S_EXEC: begin
        oe_nxt    = !s_cs_b;
        state_nxt = s_cs_b ? asid_pkg::S_IDLE : asid_pkg::S_LOAD;
      end
      default: begin
        state_nxt = asid_pkg::S_IDLE;
      end
    endcase
    if (!rst_b) begin
      state_nxt = asid_pkg::S_IDLE;
      cnt_nxt   = 5'h00;
      len_nxt   = 5'h0D;
      instr_nxt = 8'h00;
      word_nxt  = 17'h00000;
      msbf_nxt  = 1'b1;
      sdo_nxt   = 1'b0;
      oe_nxt    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_r <= state_nxt;
    cnt_r   <= cnt_nxt;
    len_r   <= len_nxt;
    instr_r <= instr_nxt;
    word_r  <= word_nxt;
    msbf_r  <= msbf_nxt;
    sdo_r   <= sdo_nxt;
    oe_r    <= oe_nxt;
  end

  assign serial_data_out = sdo_r;
  assign serial_data_oe  = oe_r;

  // ----------------------------------------
  // instruction execution
  // ----------------------------------------
  logic       exec, run;
  logic [5:0] acq_r, acq_nxt;
  logic [1:0] src_r, src_nxt;
  logic [2:0] pos_r, pos_nxt, neg_r, neg_nxt;
  logic       test_r, test_nxt, pdc_r, pdc_nxt, pwd_r, pwd_nxt;
  logic       cs_r, cs_nxt, c8_r, c8_nxt, cal_r, cal_nxt, az_r, az_nxt;
  logic       com_r, com_nxt;

  assign exec = (state_r == asid_pkg::S_EXEC);
  // read-only select and the power-down pin both block execution
  assign run  = exec && !s_ro && !s_pdn;

  always_comb begin
    fmt_nxt  = fmt_r;
    sign_nxt = sign_r;
    msb_nxt  = msb_r;
    stat_nxt = exec ? 1'b0 : stat_r;
    acq_nxt  = acq_r;
    src_nxt  = src_r;
    pos_nxt  = pos_r;
    neg_nxt  = neg_r;
    com_nxt  = com_r;
    test_nxt = test_r;
    pdc_nxt  = pdc_r;
    cs_nxt   = 1'b0;
    c8_nxt   = c8_r;
    cal_nxt  = 1'b0;
    az_nxt   = 1'b0;
    if (run) begin
      case (dif.mode)
        asid_pkg::MODE_C12_MSB, asid_pkg::MODE_C16_MSB, asid_pkg::MODE_C8_MSB,
        asid_pkg::MODE_C12_LSB, asid_pkg::MODE_C16_LSB,
        asid_pkg::MODE_C8_LSB: begin
          cs_nxt  = 1'b1;
          src_nxt = asid_pkg::SRC_INPUT;
          pos_nxt = dif.pos_ch;
          neg_nxt = dif.neg_ch;
          com_nxt = dif.neg_com;
          msb_nxt = !dif.mode[2];
          c8_nxt  = dif.mode[1];
          fmt_nxt = dif.mode[1] ? asid_pkg::FMT8
                  : dif.mode[0] ? asid_pkg::FMT16 : asid_pkg::FMT12;
        end
        asid_pkg::MODE_FULLSC, asid_pkg::MODE_OFFSET: begin
          if (dif.addr_zero) begin
            cs_nxt  = 1'b1;
            c8_nxt  = 1'b0;
            fmt_nxt = asid_pkg::FMT12;
            msb_nxt = !dif.mode[2];
            src_nxt = dif.mode[2] ? asid_pkg::SRC_OFFSET : asid_pkg::SRC_FULLSC;
          end
        end
        asid_pkg::MODE_AUTOCAL:  cal_nxt  = dif.addr_zero;
        asid_pkg::MODE_AUTOZERO: az_nxt   = dif.addr_zero;
        asid_pkg::MODE_PWR_UP:   pdc_nxt  = dif.addr_zero ? 1'b0 : pdc_r;
        asid_pkg::MODE_PWR_DN:   pdc_nxt  = dif.addr_zero ? 1'b1 : pdc_r;
        asid_pkg::MODE_STATUS:   stat_nxt = dif.addr_zero;
        asid_pkg::MODE_SIGN: begin
          if (dif.mid_zero) begin
            sign_nxt = dif.a0;
          end
        end
        asid_pkg::MODE_ACQ: begin
          if (dif.hi_zero) begin
            case ({dif.a0, dif.a1})
              2'h0:    acq_nxt = asid_pkg::ACQ_6;
              2'h1:    acq_nxt = asid_pkg::ACQ_10;
              2'h2:    acq_nxt = asid_pkg::ACQ_18;
              default: acq_nxt = asid_pkg::ACQ_34;
            endcase
          end
        end
        default: begin
          // test mode entry ignores the other address bits; leaving it needs all address bits zero
          if (dif.a0) begin
            test_nxt = 1'b1;
          end else if (dif.addr_zero) begin
            test_nxt = 1'b0;
          end
        end
      endcase
    end
    pwd_nxt = pdc_nxt | s_pdn;
    if (!rst_b) begin
      fmt_nxt  = asid_pkg::FMT12;
      sign_nxt = 1'b1;
      msb_nxt  = 1'b1;
      stat_nxt = 1'b0;
      acq_nxt  = asid_pkg::ACQ_RESET;
      src_nxt  = asid_pkg::SRC_INPUT;
      pos_nxt  = 3'h0;
      neg_nxt  = 3'h1;
      com_nxt  = 1'b0;
      test_nxt = 1'b0;
      pdc_nxt  = 1'b0;
      pwd_nxt  = 1'b0;
      cs_nxt   = 1'b0;
      c8_nxt   = 1'b0;
      cal_nxt  = 1'b0;
      az_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    fmt_r  <= fmt_nxt;
    sign_r <= sign_nxt;
    msb_r  <= msb_nxt;
    stat_r <= stat_nxt;
    acq_r  <= acq_nxt;
    src_r  <= src_nxt;
    pos_r  <= pos_nxt;
    neg_r  <= neg_nxt;
    com_r  <= com_nxt;
    test_r <= test_nxt;
    pdc_r  <= pdc_nxt;
    pwd_r  <= pwd_nxt;
    cs_r   <= cs_nxt;
    c8_r   <= c8_nxt;
    cal_r  <= cal_nxt;
    az_r   <= az_nxt;
  end

  assign conv_start         = cs_r;
  assign conv_8bit          = c8_r;
  assign conv_source        = src_r;
  assign autocal_start      = cal_r;
  assign autozero_start     = az_r;
  assign power_down         = pwd_r;
  assign acq_cycles         = acq_r;
  assign test_mode          = test_r;
  assign ch_test_oe         = {7{test_r}};
  assign mux_output_pos_sel = pos_r;
  assign mux_output_neg_sel = neg_r;
  assign mux_output_neg_com = com_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_run;
    exec ##0 !s_ro ##0 !s_pdn;
  endsequence

  sequence seq_last_bit;
    (state_r == asid_pkg::S_SHIFT) && !s_cs_b && s_rise ##0 (cnt_r == len_r - 5'h01);
  endsequence

  chk_conv_start_cause: assert property (conv_start |-> $past(run))
    else $error("conversion started without an executed instruction");
  chk_ro_no_conv: assert property (exec && s_ro |=> !conv_start)
    else $error("conversion started in read-only frame");
  chk_pdn_pin_force: assert property (s_pdn |=> power_down)
    else $error("power-down pin did not force power down");
  chk_reset_defaults: assert property ($rose(rst_b) |-> acq_cycles == asid_pkg::ACQ_10
      && fmt_r == asid_pkg::FMT12 && sign_r && msb_r && !test_mode)
    else $error("power-up defaults wrong");
  chk_frame_length: assert property (seq_last_bit |=> state_r == asid_pkg::S_EXEC)
    else $error("frame did not end at word length");
  chk_cmd_keeps_fmt: assert property (seq_run ##0 dif.mode[3] |=>
      $stable(fmt_r) && $stable(msb_r))
    else $error("control command changed the output format");
  chk_test_select: assert property (seq_run ##0 dif.mode == asid_pkg::MODE_TESTSEL
      && dif.a0 |=> test_mode && ch_test_oe == 7'h7F)
    else $error("test mode not entered");
  chk_lsb_modes: assert property (seq_run ##0 dif.mode == asid_pkg::MODE_C8_LSB
      |=> !msb_r && fmt_r == asid_pkg::FMT8 ##1 !status_word[asid_pkg::ST_JUST])
    else $error("lsb-first 8-bit mode not applied");

endmodule // asid_top

`default_nettype wire

// [verif/asid_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module asid_host_model (
  // clock
  input  wire logic clk,
  // serial pins toward the device
  output logic      sclk_pin,
  output logic      select_pin_b,
  output logic      serial_instruction_in,
  output logic      read_only_sel,
  output logic      powerdown_pin,
  // device answer
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe
);
  initial begin
    sclk_pin = 1'b0;
    select_pin_b = 1'b1;
    serial_instruction_in = 1'b0;
    read_only_sel = 1'b0;
    powerdown_pin = 1'b0;
  end

  // ----------------------------------------
  // one strobed frame, 80 ns serial clock
  // ----------------------------------------
  // sclk stands still between frames; the power-down pin is left as given
  task automatic frame(input logic [7:0] ins, input logic [4:0] len, input logic ro,
                       input logic pdn, output logic [16:0] word);
    word = 17'h00000;
    @(posedge clk);
    select_pin_b <= 1'b0;
    read_only_sel <= ro;
    powerdown_pin <= pdn;
    repeat (8) @(posedge clk);
    for (int i = 0; i < len; i++) begin
      serial_instruction_in <= (i < 8) ? ins[i] : ~serial_instruction_in;
      repeat (3) @(posedge clk);
      @(negedge clk);
      // a bit taken while the driver is off counts as unknown
      word[i] = serial_data_oe ? serial_data_out : 1'bx;
      @(posedge clk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
    end
    select_pin_b <= 1'b1;
    read_only_sel <= 1'b0;
  endtask
endmodule // asid_host_model

`default_nettype wire

// [verif/asid_top_test.sv]
`timescale 1ns/1ns
`default_nettype none

module asid_top_test;
  // ----------------------------------------
  // clock, core side and reference state
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [12:0] res = 13'h0000;
  logic [2:0]  flg = 3'h0;
  int          seed = 32'h7434;
  int          fails = 0;
  int          total_checks = 0;
  int          n_conv = 0, n_cal = 0, n_zero = 0;
  wire logic   sclk, sel_b, sdi, ro, pdp, sdo, oe, cst, c8, acs, azs, pdn, tm, mc;
  wire logic [1:0] src;
  wire logic [5:0] acq;
  wire logic [7:1] choe;
  wire logic [2:0] mp, mn;
  logic [1:0]  fmt = 2'h1;
  logic        sgn = 1'b1, msb = 1'b1, tst = 1'b0, pdc = 1'b0, pend = 1'b0, lpd = 1'b0;
  logic        ec = 1'b0;
  logic [2:0]  ep = 3'h0, en = 3'h1;
  logic [5:0]  acq_e = asid_pkg::ACQ_RESET;
  logic [5:0]  acqt [4] = '{asid_pkg::ACQ_6, asid_pkg::ACQ_10, asid_pkg::ACQ_18, asid_pkg::ACQ_34};
  logic [3:0]  cm [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (cst === 1'b1) n_conv++;
    if (acs === 1'b1) n_cal++;
    if (azs === 1'b1) n_zero++;
  end

  asid_top dut_u (
    .clk(clk), .rst_b(rst_b), .sclk_pin(sclk), .select_pin_b(sel_b),
    .serial_instruction_in(sdi), .read_only_sel(ro), .powerdown_pin(pdp),
    .serial_data_out(sdo), .serial_data_oe(oe), .conv_result(res),
    .powerup_busy_flag(flg[0]), .powerdown_busy_flag(flg[1]), .cal_busy_flag(flg[2]),
    .conv_start(cst), .conv_8bit(c8), .conv_source(src), .autocal_start(acs),
    .autozero_start(azs), .power_down(pdn), .acq_cycles(acq), .test_mode(tm),
    .ch_test_oe(choe), .mux_output_pos_sel(mp), .mux_output_neg_sel(mn),
    .mux_output_neg_com(mc)
  );

  asid_host_model host_u (
    .clk(clk), .sclk_pin(sclk), .select_pin_b(sel_b), .serial_instruction_in(sdi),
    .read_only_sel(ro), .powerdown_pin(pdp), .serial_data_out(sdo), .serial_data_oe(oe)
  );

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [16:0] want, input logic [16:0] got);
    total_checks++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // serial word in send order, bit 0 goes out first
  function automatic logic [16:0] ew(input logic [12:0] r);
    logic [16:0] d;
    logic [16:0] w;
    int n;
    int p;
    n = (fmt == 2'h0 ? 8 : 12) + int'(sgn);
    p = (fmt == 2'h2) ? 4 : 0;
    d = (fmt == 2'h0) ? {8'h00, r[12], r[11:4]} : {4'h0, r};
    if (!sgn) d[n] = 1'b0;
    w = 17'h00000;
    for (int i = 0; i < n; i++) begin
      if (msb) w[p + i] = d[n - 1 - i];
      else w[i] = d[i];
    end
    return w;
  endfunction

  task automatic outs();
    chk("acq count", 17'(acq_e), 17'(acq));
    chk("test mode", 17'({8{tst}}), 17'({choe, tm}));
    chk("power down", 17'(pdc | lpd), 17'(pdn));
    chk("mux select", 17'({ep, ec}), 17'({mp, mc}));
    if (!ec) chk("mux negative", 17'(en), 17'(mn));
    chk("output enable idle", 17'h00000, 17'(oe));
  endtask

  task automatic run(input logic [3:0] a, input logic [3:0] m, input logic r_o,
                     input logic p_d);
    logic [12:0] r;
    logic [2:0]  f;
    logic [16:0] want, got;
    logic [4:0]  len;
    int          c0, c1, c2;
    logic        cv, cal, zer, e8;
    logic [1:0]  es;
    r = 13'($random(seed));
    f = 3'($random(seed));
    @(posedge clk);
    res <= r;
    flg <= f;
    len = 5'((fmt == 2'h0 ? 8 : fmt == 2'h1 ? 12 : 16) + int'(sgn));
    want = pend ? {8'h00, tst, msb, sgn, fmt == 2'h2, fmt == 2'h1, fmt == 2'h0, f} : ew(r);
    want = want & ((17'h00001 << len) - 17'h00001);
    c0 = n_conv;
    c1 = n_cal;
    c2 = n_zero;
    host_u.frame({m[0], m[1], m[2], m[3], a}, len, r_o, p_d, got);
    repeat (10) @(posedge clk);
    chk("data word", want, got);
    {cv, cal, zer, e8, es} = 6'h00;
    pend = 1'b0;
    lpd = p_d;
    if (!r_o && !p_d) begin
      if (m < 4'h8 && m[1:0] != 2'h3) begin
        cv = 1'b1;
        fmt = m[1] ? 2'h0 : m[0] ? 2'h2 : 2'h1;
        msb = !m[2];
        e8 = m[1];
        ep = {a[2], a[3], a[1]};
        ec = a[0];
        if (!a[0]) en = {a[2], a[3], ~a[1]};
      end else if (m < 4'h8) begin
        cv = 1'b1;
        fmt = 2'h1;
        msb = !m[2];
        es = m[2] ? asid_pkg::SRC_OFFSET : asid_pkg::SRC_FULLSC;
      end
      cal = (m == asid_pkg::MODE_AUTOCAL);
      zer = (m == asid_pkg::MODE_AUTOZERO);
      if (m == asid_pkg::MODE_PWR_UP) pdc = 1'b0;
      if (m == asid_pkg::MODE_PWR_DN) pdc = 1'b1;
      if (m == asid_pkg::MODE_STATUS) pend = 1'b1;
      if (m == asid_pkg::MODE_SIGN) sgn = a[0];
      if (m == asid_pkg::MODE_ACQ) acq_e = acqt[{a[0], a[1]}];
      if (m == asid_pkg::MODE_TESTSEL) tst = a[0];
    end
    if (cv) chk("conv control", 17'({e8, es}), 17'({c8, src}));
    chk("conv starts", 17'(cv), 17'(n_conv - c0));
    chk("cal starts", 17'(cal), 17'(n_cal - c1));
    chk("zero starts", 17'(zer), 17'(n_zero - c2));
    outs();
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [3:0] m, a;
    logic [5:0] b;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    outs();
    run(4'h0, asid_pkg::MODE_STATUS, 1'b0, 1'b0);
    run(4'h0, asid_pkg::MODE_SIGN, 1'b0, 1'b0);
    for (int k = 0; k < 16; k++) run(4'(k), cm[k % 6], 1'b0, 1'b0);
    run(4'h1, asid_pkg::MODE_SIGN, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) run(4'(k), asid_pkg::MODE_ACQ, 1'b0, 1'b0);
    for (int k = 7; k < 13; k++) run(4'h0, 4'(k), 1'b0, 1'b0);
    run(4'h0, asid_pkg::MODE_FULLSC, 1'b0, 1'b0);
    run(4'hB, asid_pkg::MODE_TESTSEL, 1'b0, 1'b0);
    run(4'h0, asid_pkg::MODE_TESTSEL, 1'b0, 1'b0);
    run(4'h6, asid_pkg::MODE_C8_MSB, 1'b1, 1'b0);
    run(4'h6, asid_pkg::MODE_C12_MSB, 1'b0, 1'b1);
    for (int k = 0; k < 30; k++) begin
      m = 4'($random(seed));
      a = 4'($random(seed));
      b = 6'($random(seed));
      if (m == 4'h3 || (m >= 4'h7 && m <= 4'hC)) a = 4'h0;
      if (m == 4'hD) a = {3'h0, a[0]};
      if (m == 4'hE) a = {2'h0, a[1:0]};
      if (m == 4'hF && !a[0]) a = 4'h0;
      run(a, m, !pend && b[2:0] == 3'h0, !pend && b[5:3] == 3'h0);
    end
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // asid_top_test

`default_nettype wire
